// >>> verilog/mcu_interrupt_control.sv
// interrupt flags, masks, edge selection, priority and entry sequence
module mcu_interrupt_control
    import irq_ctrl_pkg::*;
(
    input wire logic clock_i, // system clock
    input wire logic rstn_i, // async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr_i, // nibble address
    input wire logic [DATA_W-1:0] reg_wdata_i, // write nibble
    input wire logic [DATA_W-1:0] reg_bit_we_i, // per-bit write strobe
    input wire logic reg_rd_i, // read strobe
    output logic [DATA_W-1:0] reg_rdata_o, // read nibble, next cycle
    input wire logic ext_input_zero_n_i, // external input 0 pin
    input wire logic ext_input_one_n_i, // external input 1 pin
    input wire logic ext_input_two_i, // external input 2 pin
    input wire logic ext_input_three_i, // external input 3 pin
    input wire logic ext_input_four_i, // external input 4 pin
    input wire logic timer_event_input_i, // timer D event pin
    input wire logic stop_release_input_n_i, // stop-release pin
    input wire logic stop_mode_i, // device is in stop mode
    input wire logic tmr_a_ovf_i, // timer A overflow pulse
    input wire logic tmr_c_ovf_i, // timer C overflow pulse
    input wire logic tmr_d_ovf_i, // timer D overflow pulse
    input wire logic tmr_d_capture_en_i, // input capture in use
    input wire logic serial_done_i, // serial transfer complete
    input wire logic serial_suspend_i, // serial transfer suspended
    input wire logic return_from_irq_instr_i, // return executes
    output logic irq_request_o, // unmasked request pending
    output logic seq_finish_o, // entry cycle one
    output logic seq_push_o, // entry cycles two and three
    output logic seq_jump_o, // entry cycle three
    output logic [VEC_W-1:0] vector_o, // vector address
    output logic stop_release_o // stop-release request pulse
);

    // ------------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------------
    function automatic bit_map_t bit_map(input logic [ADDR_W-1:0] a,
                                         input logic [1:0] b);
        bit_map_t m;
        m = '0;
        m.hit = 1'b1;
        unique case (a)
            OFF_N0: begin
                m.is_ie = (b == BIT_IE);
                m.is_mask = (b == BIT_HI_MASK);
                m.src = SRC_E0;
                m.hit = (b != 2'h1);
            end
            OFF_N1: begin
                m.is_mask = b[0];
                m.src = b[1] ? SRC_TA : SRC_E1;
            end
            OFF_TC: begin
                m.is_mask = b[0];
                m.src = SRC_TC;
                m.hit = b[1];
            end
            OFF_TDS: begin
                m.is_mask = b[0];
                m.src = b[1] ? SRC_S1 : SRC_TD;
            end
            OFF_EXT_A: begin
                m.is_mask = b[0];
                m.src = b[1] ? SRC_E3 : SRC_E2;
            end
            OFF_EXT_B: begin
                m.is_mask = b[0];
                m.src = SRC_E4;
                m.hit = ~b[1];
            end
            default: m.hit = 1'b0;
        endcase
        return m;
    endfunction

    function automatic logic [VEC_W-1:0] prio_vector(
        input logic [NUM_CH-1:0] req);
        logic [VEC_W-1:0] v;
        v = VEC_BASE;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (req[i]) begin
                v = VEC_BASE + VEC_W'(i) * VEC_STEP;
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // pin edges
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] edge_select_one_q, edge_select_one_d;
    logic [DATA_W-1:0] edge_select_two_q, edge_select_two_d;
    logic [NUM_PIN-1:0] pins;
    logic [NUM_PIN-1:0] edges;
    logic [1:0] modes [NUM_PIN];

    assign pins = {stop_release_input_n_i, timer_event_input_i,
                   ext_input_four_i, ext_input_three_i, ext_input_two_i,
                   ext_input_one_n_i, ext_input_zero_n_i};

    always_comb begin
        modes[0] = EDGE_FALL;
        modes[1] = EDGE_FALL;
        modes[2] = edge_select_one_q[1:0];
        modes[3] = edge_select_one_q[3:2];
        modes[4] = edge_select_two_q[1:0];
        modes[5] = edge_select_two_q[3:2];
        modes[6] = EDGE_FALL;
    end

    for (genvar g = 0; g < NUM_PIN; g++) begin : g_pin
        irq_edge_detect u_edge (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .pin_i(pins[g]),
            .mode_i(modes[g]),
            .edge_o(edges[g])
        );
    end

    // ------------------------------------------------------------------
    // flags, masks, enable, edge selects
    // ------------------------------------------------------------------
    logic ie_q, ie_d;
    logic [NUM_SRC-1:0] flag_q, flag_d;
    logic [NUM_SRC-1:0] mask_q, mask_d;
    logic [NUM_SRC-1:0] set_ev, clr_ev;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_CH-1:0] req;
    seq_state_t state_q, state_d;
    bit_map_t wm;

    always_comb begin
        set_ev = '0;
        set_ev[SRC_E0] = edges[0];
        set_ev[SRC_E1] = edges[1];
        set_ev[SRC_TA] = tmr_a_ovf_i;
        set_ev[SRC_E2] = edges[2];
        set_ev[SRC_TC] = tmr_c_ovf_i;
        set_ev[SRC_E3] = edges[3];
        set_ev[SRC_TD] = tmr_d_ovf_i | (edges[5] & tmr_d_capture_en_i);
        set_ev[SRC_E4] = edges[4];
        set_ev[SRC_S1] = serial_done_i | serial_suspend_i;
        clr_ev = '0;
        mask_d = mask_q;
        ie_d = ie_q;
        edge_select_one_d = edge_select_one_q;
        edge_select_two_d = edge_select_two_q;
        wm = '0;
        for (int b = 0; b < DATA_W; b++) begin
            wm = bit_map(reg_addr_i, 2'(b));
            if (reg_bit_we_i[b] && wm.hit) begin
                if (wm.is_ie) begin
                    ie_d = reg_wdata_i[b];
                end else if (wm.is_mask) begin
                    mask_d[wm.src] = reg_wdata_i[b];
                end else if (!reg_wdata_i[b]) begin
                    clr_ev[wm.src] = 1'b1;
                end
            end
            if (reg_bit_we_i[b] && reg_addr_i == OFF_EDGE_SELECT_ONE) begin
                edge_select_one_d[b] = reg_wdata_i[b];
            end
            if (reg_bit_we_i[b] && reg_addr_i == OFF_EDGE_SELECT_TWO) begin
                edge_select_two_d[b] = reg_wdata_i[b];
            end
        end
        if (return_from_irq_instr_i) begin
            ie_d = 1'b1;
        end
        if (state_q == S_FINISH) begin
            ie_d = 1'b0;
        end
        // a set in the same cycle as a clear is kept
        flag_d = set_ev | (flag_q & ~clr_ev);
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ie_q <= IE_RST;
            flag_q <= FLAG_RST;
            mask_q <= MASK_RST;
            edge_select_one_q <= ESR_RST;
            edge_select_two_q <= ESR_RST;
        end else begin
            ie_q <= ie_d;
            flag_q <= flag_d;
            mask_q <= mask_d;
            edge_select_one_q <= edge_select_one_d;
            edge_select_two_q <= edge_select_two_d;
        end
    end

    // ------------------------------------------------------------------
    // channel requests
    // ------------------------------------------------------------------
    always_comb begin
        pend = flag_q & ~mask_q;
        req[0] = pend[SRC_E0];
        req[1] = pend[SRC_E1];
        req[2] = pend[SRC_TA];
        req[3] = pend[SRC_E2];
        req[4] = pend[SRC_TC] | pend[SRC_E3];
        req[5] = pend[SRC_TD] | pend[SRC_E4];
        req[6] = pend[SRC_S1];
    end

    // ------------------------------------------------------------------
    // entry sequence and outputs
    // ------------------------------------------------------------------
    logic accept;
    logic [VEC_W-1:0] vec_q, vec_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic irq_req_q, irq_req_d;
    logic finish_q, finish_d;
    logic push_q, push_d;
    logic jump_q, jump_d;
    logic stop_rel_q, stop_rel_d;
    bit_map_t rm;

    always_comb begin
        accept = (state_q == S_IDLE) && ie_q && (|req);
        state_d = state_q;
        vec_d = vec_q;
        unique case (state_q)
            S_IDLE: begin
                if (accept) begin
                    state_d = S_FINISH;
                    vec_d = prio_vector(req);
                end
            end
            S_FINISH: state_d = S_PUSH;
            S_PUSH: state_d = S_JUMP;
            S_JUMP: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
        finish_d = (state_d == S_FINISH);
        push_d = (state_d == S_PUSH) || (state_d == S_JUMP);
        jump_d = (state_d == S_JUMP);
        irq_req_d = |req;
        stop_rel_d = edges[6] & stop_mode_i;
        rdata_d = rdata_q;
        rm = '0;
        if (reg_rd_i) begin
            for (int b = 0; b < DATA_W; b++) begin
                rm = bit_map(reg_addr_i, 2'(b));
                // edge selects are write-only and read as zero
                rdata_d[b] = rm.hit & (rm.is_ie ? ie_q :
                             rm.is_mask ? mask_q[rm.src] : flag_q[rm.src]);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= S_IDLE;
            vec_q <= VEC_BASE;
            finish_q <= 1'b0;
            push_q <= 1'b0;
            jump_q <= 1'b0;
            irq_req_q <= 1'b0;
            stop_rel_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            vec_q <= vec_d;
            finish_q <= finish_d;
            push_q <= push_d;
            jump_q <= jump_d;
            irq_req_q <= irq_req_d;
            stop_rel_q <= stop_rel_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_request_o = irq_req_q;
    assign seq_finish_o = finish_q;
    assign seq_push_o = push_q;
    assign seq_jump_o = jump_q;
    assign vector_o = vec_q;
    assign stop_release_o = stop_rel_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_accept_enabled;
        @(posedge clock_i) disable iff (!rstn_i)
        (state_q == S_IDLE && ie_q && |req) |=> seq_finish_o;
    endproperty
    a_accept_enabled: assert property (p_accept_enabled)
        else $error("qualifying request not accepted");

    property p_disabled_blocks;
        @(posedge clock_i) disable iff (!rstn_i)
        (state_q == S_IDLE && !ie_q) |=> !seq_finish_o;
    endproperty
    a_disabled_blocks: assert property (p_disabled_blocks)
        else $error("interrupt taken while disabled");

    property p_top_priority;
        @(posedge clock_i) disable iff (!rstn_i)
        (accept && req[0]) |=> (vector_o == VEC_BASE);
    endproperty
    a_top_priority: assert property (p_top_priority)
        else $error("input 0 lost priority");

    property p_entry_seq;
        @(posedge clock_i) disable iff (!rstn_i)
        seq_finish_o |=> (seq_push_o && !ie_q && !seq_jump_o)
            ##1 (seq_push_o && seq_jump_o) ##1 !seq_push_o;
    endproperty
    a_entry_seq: assert property (p_entry_seq)
        else $error("entry sequence out of step");

    property p_return_sets;
        @(posedge clock_i) disable iff (!rstn_i)
        (return_from_irq_instr_i && state_q != S_FINISH) |=> ie_q;
    endproperty
    a_return_sets: assert property (p_return_sets)
        else $error("return did not re-enable");

    property p_serial_set;
        @(posedge clock_i) disable iff (!rstn_i)
        (serial_done_i || serial_suspend_i) |=> flag_q[SRC_S1];
    endproperty
    a_serial_set: assert property (p_serial_set)
        else $error("serial flag not set");

    property p_tmr_a_set;
        @(posedge clock_i) disable iff (!rstn_i)
        tmr_a_ovf_i |=> flag_q[SRC_TA];
    endproperty
    a_tmr_a_set: assert property (p_tmr_a_set)
        else $error("timer A flag not set");

    property p_stop_ignored;
        @(posedge clock_i) disable iff (!rstn_i)
        !stop_mode_i |=> !stop_release_o;
    endproperty
    a_stop_ignored: assert property (p_stop_ignored)
        else $error("stop release outside stop mode");

    property p_vector_range;
        @(posedge clock_i) disable iff (!rstn_i)
        seq_jump_o |-> (!vector_o[0] && vector_o >= VEC_BASE
            && vector_o <= VEC_LAST);
    endproperty
    a_vector_range: assert property (p_vector_range)
        else $error("vector out of range");

    property p_masked_idle;
        @(posedge clock_i) disable iff (!rstn_i)
        (state_q == S_IDLE && req == '0) |=> !seq_finish_o;
    endproperty
    a_masked_idle: assert property (p_masked_idle)
        else $error("masked request accepted");

endmodule

// >>> verilog/irq_ctrl_pkg.sv
// constants and types shared by the interrupt control block
package irq_ctrl_pkg;

    // ------------------------------------------------------------------
    // nibble bus
    // ------------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 4;

    localparam logic [ADDR_W-1:0] OFF_N0 = 10'h000;
    localparam logic [ADDR_W-1:0] OFF_N1 = 10'h001;
    localparam logic [ADDR_W-1:0] OFF_TC = 10'h002;
    localparam logic [ADDR_W-1:0] OFF_TDS = 10'h003;
    localparam logic [ADDR_W-1:0] OFF_EXT_A = 10'h022;
    localparam logic [ADDR_W-1:0] OFF_EXT_B = 10'h023;
    localparam logic [ADDR_W-1:0] OFF_EDGE_SELECT_ONE = 10'h026;
    localparam logic [ADDR_W-1:0] OFF_EDGE_SELECT_TWO = 10'h027;

    // ------------------------------------------------------------------
    // field positions inside a nibble
    // ------------------------------------------------------------------
    localparam logic [1:0] BIT_IE = 2'h0;
    localparam logic [1:0] BIT_LO_FLAG = 2'h0;
    localparam logic [1:0] BIT_LO_MASK = 2'h1;
    localparam logic [1:0] BIT_HI_FLAG = 2'h2;
    localparam logic [1:0] BIT_HI_MASK = 2'h3;

    // ------------------------------------------------------------------
    // request sources and channels
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 9;
    localparam int NUM_CH = 7;
    localparam int NUM_PIN = 7;
    localparam logic [3:0] SRC_E0 = 4'h0;
    localparam logic [3:0] SRC_E1 = 4'h1;
    localparam logic [3:0] SRC_TA = 4'h2;
    localparam logic [3:0] SRC_E2 = 4'h3;
    localparam logic [3:0] SRC_TC = 4'h4;
    localparam logic [3:0] SRC_E3 = 4'h5;
    localparam logic [3:0] SRC_TD = 4'h6;
    localparam logic [3:0] SRC_E4 = 4'h7;
    localparam logic [3:0] SRC_S1 = 4'h8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic IE_RST = 1'b0;
    localparam logic [NUM_SRC-1:0] FLAG_RST = 9'h000;
    localparam logic [NUM_SRC-1:0] MASK_RST = 9'h1ff;
    localparam logic [DATA_W-1:0] ESR_RST = 4'h0;

    // ------------------------------------------------------------------
    // edge codes and vectors
    // ------------------------------------------------------------------
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam int VEC_W = 16;
    localparam logic [VEC_W-1:0] VEC_BASE = 16'h0002;
    localparam logic [VEC_W-1:0] VEC_STEP = 16'h0002;
    localparam logic [VEC_W-1:0] VEC_LAST = 16'h000e;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_FINISH = 4'b0010,
        S_PUSH = 4'b0100,
        S_JUMP = 4'b1000
    } seq_state_t;

    typedef struct packed {
        logic hit;
        logic is_ie;
        logic is_mask;
        logic [3:0] src;
    } bit_map_t;

endpackage

// >>> verilog/irq_edge_detect.sv
// pin synchroniser with selectable edge detection
module irq_edge_detect
    import irq_ctrl_pkg::*;
(
    input wire logic clock_i, // system clock
    input wire logic rstn_i, // async reset, active low
    input wire logic pin_i, // asynchronous pin level
    input wire logic [1:0] mode_i, // edge select code
    output logic edge_o // one-cycle pulse on chosen edge
);

    // ------------------------------------------------------------------
    // synchroniser and edge
    // ------------------------------------------------------------------
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;
    logic edge_q, edge_d;
    logic fall, rise;

    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
        prev_d = sync_q;
        fall = prev_q & ~sync_q;
        rise = ~prev_q & sync_q;
        unique case (mode_i)
            EDGE_NONE: edge_d = 1'b0;
            EDGE_FALL: edge_d = fall;
            EDGE_RISE: edge_d = rise;
            EDGE_BOTH: edge_d = fall | rise;
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            edge_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            edge_q <= edge_d;
        end
    end

    assign edge_o = edge_q;

endmodule

// >>> tb/irq_far_model.sv
// far-side model: external pins, timers, serial unit and return strobe
module irq_far_model (
    input wire logic clock_i, // system clock
    output logic ext_input_zero_n_o, // input 0 pin
    output logic ext_input_one_n_o, // input 1 pin
    output logic ext_input_two_o, // input 2 pin
    output logic ext_input_three_o, // input 3 pin
    output logic ext_input_four_o, // input 4 pin
    output logic timer_event_input_o, // timer D event pin
    output logic tmr_d_capture_en_o, // input capture in use
    output logic stop_release_input_n_o, // stop-release pin
    output logic stop_mode_o, // stop mode level
    output logic tmr_a_ovf_o, // timer A overflow
    output logic tmr_c_ovf_o, // timer C overflow
    output logic tmr_d_ovf_o, // timer D overflow
    output logic serial_done_o, // serial transfer done
    output logic serial_suspend_o, // serial transfer suspended
    output logic return_from_irq_instr_o // return executes
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {ext_input_zero_n_o, ext_input_one_n_o} = 2'h3;
        {ext_input_two_o, stop_mode_o, return_from_irq_instr_o} = 3'h0;
        stop_release_input_n_o = 1'b1;
        {tmr_a_ovf_o, tmr_c_ovf_o, tmr_d_ovf_o, serial_done_o} = 4'h0;
        {ext_input_three_o, ext_input_four_o, timer_event_input_o} = 3'h0;
        {tmr_d_capture_en_o, serial_suspend_o} = 2'h0;
    end
    // one event numbered ch (only 0 to 6 match their channel); pins are held for several cycles
    task automatic fire(input int ch);
        @(posedge clock_i);
        case (ch)
            0: ext_input_zero_n_o <= 1'b0;
            1: ext_input_one_n_o <= 1'b0;
            2: tmr_a_ovf_o <= 1'b1;
            3: ext_input_two_o <= 1'b1;
            4: tmr_c_ovf_o <= 1'b1;
            5: tmr_d_ovf_o <= 1'b1;
            6: serial_done_o <= 1'b1;
            7: ext_input_three_o <= 1'b1;
            8: ext_input_four_o <= 1'b1;
            9: {timer_event_input_o, tmr_d_capture_en_o} <= 2'h3;
            default: serial_suspend_o <= 1'b1;
        endcase
        @(posedge clock_i);
        {tmr_a_ovf_o, tmr_c_ovf_o, tmr_d_ovf_o, serial_done_o} <= 4'h0;
        serial_suspend_o <= 1'b0;
        repeat (3) @(posedge clock_i);
        {ext_input_zero_n_o, ext_input_one_n_o} <= 2'h3;
        {ext_input_two_o, ext_input_three_o, ext_input_four_o} <= 3'h0;
        {timer_event_input_o, tmr_d_capture_en_o} <= 2'h0;
    endtask
    task automatic ret();
        @(posedge clock_i);
        return_from_irq_instr_o <= 1'b1;
        @(posedge clock_i);
        return_from_irq_instr_o <= 1'b0;
    endtask
    task automatic stop_pulse(input logic mode);
        @(posedge clock_i);
        stop_mode_o <= mode;
        stop_release_input_n_o <= 1'b0;
        repeat (4) @(posedge clock_i);
        stop_release_input_n_o <= 1'b1;
    endtask
endmodule

// >>> tb/mcu_interrupt_control_bench.sv
// self-checking bench for the interrupt control block
module mcu_interrupt_control_bench
    import irq_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, rstn_i = 1'b0, reg_rd_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i = 10'h000;
    logic [DATA_W-1:0] reg_wdata_i = 4'h0, reg_bit_we_i = 4'h0;
    logic [DATA_W-1:0] reg_rdata_o, v;
    logic e0, e1, e2, e3, e4, ev, ce, ss, sn, sm, ta, tc, td, sd, rt;
    logic irq_request_o, seq_finish_o, seq_push_o, seq_jump_o;
    logic stop_release_o;
    logic [VEC_W-1:0] vector_o;
    int mismatches = 0, samples_checked = 0, cycles = 0, n;
    logic [9:0] fa [11] = '{10'h000, 10'h001, 10'h001, 10'h022, 10'h002,
        10'h003, 10'h003, 10'h022, 10'h023, 10'h003, 10'h003};
    int fb [11] = '{2, 0, 2, 0, 2, 0, 2, 2, 0, 0, 2};
    int fc [11] = '{0, 1, 2, 3, 4, 5, 6, 4, 5, 5, 6};
    logic [9:0] ra [9] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h022,
        10'h023, 10'h026, 10'h027, 10'h010};
    logic [3:0] rv [9] = '{4'h8, 4'ha, 4'h8, 4'ha, 4'ha, 4'h2, 4'h0, 4'h0,
        4'h0};
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    mcu_interrupt_control u_dut (.clock_i, .rstn_i, .reg_addr_i,
        .reg_wdata_i, .reg_bit_we_i, .reg_rd_i, .reg_rdata_o,
        .ext_input_zero_n_i(e0), .ext_input_one_n_i(e1),
        .ext_input_two_i(e2), .ext_input_three_i(e3),
        .ext_input_four_i(e4), .timer_event_input_i(ev),
        .stop_release_input_n_i(sn), .stop_mode_i(sm), .tmr_a_ovf_i(ta),
        .tmr_c_ovf_i(tc), .tmr_d_ovf_i(td), .tmr_d_capture_en_i(ce),
        .serial_done_i(sd), .serial_suspend_i(ss),
        .return_from_irq_instr_i(rt), .irq_request_o, .seq_finish_o,
        .seq_push_o, .seq_jump_o, .vector_o, .stop_release_o);
    irq_far_model u_far (.clock_i, .ext_input_zero_n_o(e0),
        .ext_input_one_n_o(e1), .ext_input_two_o(e2),
        .ext_input_three_o(e3), .ext_input_four_o(e4),
        .timer_event_input_o(ev), .tmr_d_capture_en_o(ce),
        .stop_release_input_n_o(sn), .stop_mode_o(sm), .tmr_a_ovf_o(ta),
        .tmr_c_ovf_o(tc), .tmr_d_ovf_o(td), .serial_done_o(sd),
        .serial_suspend_o(ss), .return_from_irq_instr_o(rt));
    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [15:0] got, exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [3:0] d, we);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_bit_we_i <= we;
        @(posedge clock_i);
        reg_bit_we_i <= 4'h0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [3:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        d = reg_rdata_o;
    endtask
    task automatic accept(input logic [15:0] vec);
        for (int i = 0; i < 20; i++) begin
            @(negedge clock_i);
            if (seq_finish_o === 1'b1) break;
        end
        chk(16'(seq_finish_o), 16'h0001, "finish");
        chk(vector_o, vec, "vector");
        @(negedge clock_i);
        chk({seq_finish_o, seq_push_o, seq_jump_o}, 16'h2, "push");
        @(negedge clock_i);
        chk({seq_finish_o, seq_push_o, seq_jump_o}, 16'h3, "jump");
        @(negedge clock_i);
        chk({seq_finish_o, seq_push_o, seq_jump_o}, 16'h0, "end");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("Error at %0t: timeout", $time);
            finish_test();
        end
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], v);
            chk(v, rv[i], "reset value");
        end
        wr(10'h001, 4'h5, 4'h5);
        rd(10'h001, v);
        chk(v, 4'ha, "sw flag set");
        wr(10'h027, 4'hf, 4'hf);
        rd(10'h027, v);
        chk(v, 4'h0, "edge_select_two read");
        wr(10'h027, 4'h9, 4'hf);
        wr(10'h026, 4'he, 4'hf);
        $display("test registers done");
        for (int c = 0; c < 11; c++) begin
            u_far.fire(c);
            repeat (6) @(negedge clock_i);
            chk(16'(irq_request_o), 16'h0, "masked");
            wr(fa[c], 4'h0, 4'(1 << (fb[c] + 1)));
            repeat (3) @(negedge clock_i);
            chk(16'(irq_request_o), 16'h1, "request");
            chk(16'(seq_finish_o), 16'h0, "ie off");
            wr(10'h000, 4'h1, 4'h1);
            accept(16'(2 + 2 * fc[c]));
            rd(10'h000, v);
            chk(16'(v[0]), 16'h0, "ie clear");
            wr(fa[c], 4'h0, 4'(1 << fb[c]));
            wr(fa[c], 4'hf, 4'(1 << (fb[c] + 1)));
            u_far.ret();
            rd(10'h000, v);
            chk(16'(v[0]), 16'h1, "ie set");
            wr(10'h000, 4'h0, 4'h1);
        end
        $display("test channels done");
        u_far.fire(6);
        u_far.fire(2);
        wr(10'h003, 4'h0, 4'h8);
        wr(10'h001, 4'h0, 4'h8);
        wr(10'h000, 4'h1, 4'h1);
        accept(16'h0006);
        wr(10'h001, 4'h0, 4'h4);
        u_far.ret();
        accept(16'h000e);
        wr(10'h003, 4'h0, 4'h4);
        $display("test priority done");
        for (int m = 0; m < 2; m++) begin
            n = 0;
            fork
                u_far.stop_pulse(m[0]);
                repeat (10) @(negedge clock_i) n += int'(stop_release_o);
            join
            chk(16'(n != 0), 16'(m), "stop release");
        end
        $display("test stop release done");
        finish_test();
    end
endmodule
